//--- logic/tmr8_pkg.sv
package tmr8_pkg;

  localparam logic [7:0] TMR8_OFF_CTRL_A  = 8'h00;
  localparam logic [7:0] TMR8_OFF_CTRL_B  = 8'h04;
  localparam logic [7:0] TMR8_OFF_COUNT   = 8'h08;
  localparam logic [7:0] TMR8_OFF_CMP_A   = 8'h0C;
  localparam logic [7:0] TMR8_OFF_CMP_B   = 8'h10;
  localparam logic [7:0] TMR8_OFF_FLAGS   = 8'h14;
  localparam logic [7:0] TMR8_OFF_PINCFG  = 8'h18;

  localparam int TMR8_ACT_A_LSB = 6;
  localparam int TMR8_ACT_B_LSB = 4;
  localparam int TMR8_FORCE_A   = 7;
  localparam int TMR8_FORCE_B   = 6;
  localparam int TMR8_MODE_HI   = 3;

  localparam logic [7:0] TMR8_CTRL_A_RMASK = 8'hF3;
  localparam logic [7:0] TMR8_CTRL_B_RMASK = 8'h0F;
  localparam logic [7:0] TMR8_RESET_BYTE   = 8'h00;
  localparam logic [7:0] TMR8_MAX          = 8'hFF;
  localparam logic [7:0] TMR8_BOTTOM       = 8'h00;

  localparam logic [9:0] TMR8_DIV_8    = 10'h007;
  localparam logic [9:0] TMR8_DIV_64   = 10'h03F;
  localparam logic [9:0] TMR8_DIV_256  = 10'h0FF;
  localparam logic [9:0] TMR8_DIV_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    TMR8_CS_STOP = 3'h0, TMR8_CS_DIV1 = 3'h1, TMR8_CS_DIV8 = 3'h2, TMR8_CS_DIV64 = 3'h3,
    TMR8_CS_DIV256 = 3'h4, TMR8_CS_DIV1024 = 3'h5, TMR8_CS_EXT_FALL = 3'h6,
    TMR8_CS_EXT_RISE = 3'h7
  } tmr8_cs_t;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [2:0] mode;
    tmr8_cs_t   cs;
  } tmr8_cfg_t;

endpackage : tmr8_pkg

//--- logic/tmr8_edge_sync.sv
`timescale 1ns/100ps
module tmr8_edge_sync
  import tmr8_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign o_rise = sync_r & ~last_r;
  assign o_fall = ~sync_r & last_r;
endmodule : tmr8_edge_sync

//--- logic/tmr8_timer.sv
`timescale 1ns/100ps
// Behaviour
// - nonzero action B drives pin b when pin direction bit 1 is set
// - non-PWM B: off, toggle, clear, set
// - fast PWM B: clear/set match, opposite TOP
// - phase correct B: up/down match opposite actions
// - compare equals TOP: act at TOP
// - control A bits 3:2 read zero
// - mode field selects sequence and TOP
// - compare update point and overflow timing
// - force bit applies action, non-PWM only
// - force sets no flag, no clear
// - force bits read back zero
// - control B bits 5:4 read zero
// - clock select stop, div 1..1024
// - selects 6/7 count external falling/rising
// - external edges count even as output
// - counter readable and writable anytime
// - counter write blocks next match
// - compare A matched continuously, flag set
// - non-PWM A: off, toggle, clear, set
// - flags set on match or overflow, clear by one
// - compare B matched continuously
module tmr8_timer
  import tmr8_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        i_ext_count_input,
  output logic             o_chan_a_wave_out,
  output logic             o_chan_a_wave_oe,
  output logic             o_chan_b_wave_out,
  output logic             o_chan_b_wave_oe
);
  tmr8_cfg_t  cfg_r;
  logic [7:0] count_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic [7:0] cmp_a_buf_r;
  logic [7:0] cmp_b_buf_r;
  logic [2:0] flags_r;
  logic [1:0] dir_r;
  logic       down_r;
  logic       block_r;
  logic       wave_a_r;
  logic       wave_b_r;
  logic [9:0] pre_r;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       rise;
  logic       fall;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == 3'h1) || (m == 3'h3) || (m == 3'h5) || (m == 3'h7);
  endfunction : is_pwm

  function automatic logic is_phase(input logic [2:0] m);
    is_phase = (m == 3'h1) || (m == 3'h5);
  endfunction : is_phase

  // applies a non-PWM action to the current level
  function automatic logic match_act(input logic [1:0] act, input logic cur);
    case (act)
      2'b01:   match_act = ~cur;
      2'b10:   match_act = 1'b0;
      2'b11:   match_act = 1'b1;
      default: match_act = cur;
    endcase
  endfunction : match_act

  tmr8_edge_sync u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_ext_count_input),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  // ---------------- bus slave ----------------
  logic       acc;
  logic       wr_en;
  logic [7:0] wbyte;
  assign acc       = hsel & hready & htrans[1];
  assign wr_en     = wr_pend_r;
  assign wbyte     = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= TMR8_RESET_BYTE;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      if (haddr[7:0] == TMR8_OFF_CTRL_A) begin
        hrdata <= {24'h0, {cfg_r.act_a, cfg_r.act_b, 2'b00, cfg_r.mode[1:0]}
                   & TMR8_CTRL_A_RMASK};
      end else if (haddr[7:0] == TMR8_OFF_CTRL_B) begin
        hrdata <= {24'h0, {4'h0, cfg_r.mode[2], cfg_r.cs}
                   & TMR8_CTRL_B_RMASK};
      end else if (haddr[7:0] == TMR8_OFF_COUNT) begin
        hrdata <= {24'h0, count_r};
      end else if (haddr[7:0] == TMR8_OFF_CMP_A) begin
        hrdata <= {24'h0, cmp_a_buf_r};
      end else if (haddr[7:0] == TMR8_OFF_CMP_B) begin
        hrdata <= {24'h0, cmp_b_buf_r};
      end else if (haddr[7:0] == TMR8_OFF_FLAGS) begin
        hrdata <= {29'h0, flags_r};
      end else if (haddr[7:0] == TMR8_OFF_PINCFG) begin
        hrdata <= {30'h0, dir_r};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  logic wr_ca;
  logic wr_cb;
  logic wr_cnt;
  logic wr_fl;
  assign wr_ca  = wr_en && (wr_addr_r == TMR8_OFF_CTRL_A);
  assign wr_cb  = wr_en && (wr_addr_r == TMR8_OFF_CTRL_B);
  assign wr_cnt = wr_en && (wr_addr_r == TMR8_OFF_COUNT);
  assign wr_fl  = wr_en && (wr_addr_r == TMR8_OFF_FLAGS);

  // force strobes live one cycle only, never stored
  logic force_a;
  logic force_b;
  assign force_a = wr_cb && wbyte[TMR8_FORCE_A] && !is_pwm(cfg_r.mode);
  assign force_b = wr_cb && wbyte[TMR8_FORCE_B] && !is_pwm(cfg_r.mode);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= '{act_a: 2'b00, act_b: 2'b00, mode: 3'h0, cs: TMR8_CS_STOP};
      dir_r <= 2'b00;
    end else begin
      if (wr_ca) begin
        cfg_r.act_a     <= wbyte[TMR8_ACT_A_LSB +: 2];
        cfg_r.act_b     <= wbyte[TMR8_ACT_B_LSB +: 2];
        cfg_r.mode[1:0] <= wbyte[1:0];
      end
      if (wr_cb) begin
        cfg_r.mode[2] <= wbyte[TMR8_MODE_HI];
        cfg_r.cs      <= tmr8_cs_t'(wbyte[2:0]);
      end
      if (wr_en && (wr_addr_r == TMR8_OFF_PINCFG)) begin
        dir_r <= wbyte[1:0];
      end
    end
  end

  // ---------------- clock select ----------------
  logic tick;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  always_comb begin
    case (cfg_r.cs)
      TMR8_CS_DIV1:     tick = 1'b1;
      TMR8_CS_DIV8:     tick = (pre_r[2:0] == TMR8_DIV_8[2:0]);
      TMR8_CS_DIV64:    tick = (pre_r[5:0] == TMR8_DIV_64[5:0]);
      TMR8_CS_DIV256:   tick = (pre_r[7:0] == TMR8_DIV_256[7:0]);
      TMR8_CS_DIV1024:  tick = (pre_r == TMR8_DIV_1024);
      TMR8_CS_EXT_FALL: tick = fall;
      TMR8_CS_EXT_RISE: tick = rise;
      default:          tick = 1'b0;
    endcase
  end

  // ---------------- counter ----------------
  logic [7:0] top;
  logic       top_is_a;
  assign top_is_a = cfg_r.mode[2] || (cfg_r.mode == 3'h2);
  assign top = top_is_a ? cmp_a_r : TMR8_MAX;

  logic match_a;
  logic match_b;
  assign match_a = tick && !block_r && (count_r == cmp_a_r);
  assign match_b = tick && !block_r && (count_r == cmp_b_r);

  logic at_top;
  assign at_top = tick && (count_r == top);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= TMR8_RESET_BYTE;
      down_r  <= 1'b0;
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      count_r <= wbyte;
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
      if (is_phase(cfg_r.mode)) begin
        if (!down_r && count_r == top) begin
          down_r  <= 1'b1;
          count_r <= count_r - 8'h01;
        end else if (down_r && count_r == TMR8_BOTTOM) begin
          down_r  <= 1'b0;
          count_r <= count_r + 8'h01;
        end else begin
          count_r <= down_r ? count_r - 8'h01 : count_r + 8'h01;
        end
      end else if (top_is_a && count_r == top) begin
        down_r  <= 1'b0;
        count_r <= TMR8_BOTTOM;
      end else begin
        down_r  <= 1'b0;
        count_r <= count_r + 8'h01;
      end
    end
  end

  // compare registers: immediate outside PWM, at TOP in PWM
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_a_buf_r <= TMR8_RESET_BYTE;
      cmp_b_buf_r <= TMR8_RESET_BYTE;
      cmp_a_r     <= TMR8_RESET_BYTE;
      cmp_b_r     <= TMR8_RESET_BYTE;
    end else begin
      if (wr_en && wr_addr_r == TMR8_OFF_CMP_A) begin
        cmp_a_buf_r <= wbyte;
      end
      if (wr_en && wr_addr_r == TMR8_OFF_CMP_B) begin
        cmp_b_buf_r <= wbyte;
      end
      if (!is_pwm(cfg_r.mode) || at_top) begin
        cmp_a_r <= cmp_a_buf_r;
        cmp_b_r <= cmp_b_buf_r;
      end
    end
  end

  // ---------------- flags: bit2 B, bit1 A, bit0 overflow ----------------
  logic ovf;
  always_comb begin
    if (is_phase(cfg_r.mode)) begin
      ovf = tick && down_r && (count_r == TMR8_BOTTOM);
    end else if (cfg_r.mode == 3'h7) begin
      ovf = at_top;
    end else if (cfg_r.mode == 3'h4 || cfg_r.mode == 3'h6) begin
      ovf = 1'b0;
    end else begin
      ovf = tick && (count_r == TMR8_MAX);
    end
  end

  logic [2:0] fl_set;
  logic [2:0] fl_clr;
  assign fl_set = {match_b, match_a, ovf};
  assign fl_clr = wr_fl ? wbyte[2:0] : 3'b000;

  // set beats a same-cycle write-one clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_r <= 3'b000;
    end else begin
      flags_r <= fl_set | (flags_r & ~fl_clr);
    end
  end

  // ---------------- waveform generators ----------------
  logic ign_b;
  logic ign_a;
  assign ign_b = is_pwm(cfg_r.mode) && cfg_r.act_b[1] && (cmp_b_r == top);
  assign ign_a = is_pwm(cfg_r.mode) && cfg_r.act_a[1] && (cmp_a_r == top);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wave_b_r <= 1'b0;
    end else if (!is_pwm(cfg_r.mode)) begin
      if (match_b || force_b) begin
        wave_b_r <= match_act(cfg_r.act_b, wave_b_r);
      end
    end else if (cfg_r.act_b[1]) begin
      if (is_phase(cfg_r.mode)) begin
        if (ign_b && at_top) begin
          wave_b_r <= ~cfg_r.act_b[0];
        end else if (match_b && !ign_b) begin
          wave_b_r <= down_r ^ cfg_r.act_b[0];
        end
      end else if (match_b && !ign_b) begin
        wave_b_r <= cfg_r.act_b[0];
      end else if (at_top) begin
        wave_b_r <= ~cfg_r.act_b[0];
      end
    end
  end

  // channel A mirrors B; its toggle option in PWM is not provided here
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wave_a_r <= 1'b0;
    end else if (!is_pwm(cfg_r.mode)) begin
      if (match_a || force_a) begin
        wave_a_r <= match_act(cfg_r.act_a, wave_a_r);
      end
    end else if (cfg_r.act_a[1]) begin
      if (is_phase(cfg_r.mode)) begin
        if (ign_a && at_top) begin
          wave_a_r <= ~cfg_r.act_a[0];
        end else if (match_a && !ign_a) begin
          wave_a_r <= down_r ^ cfg_r.act_a[0];
        end
      end else if (match_a && !ign_a) begin
        wave_a_r <= cfg_r.act_a[0];
      end else if (at_top) begin
        wave_a_r <= ~cfg_r.act_a[0];
      end
    end
  end

  assign o_chan_b_wave_out = wave_b_r;
  assign o_chan_b_wave_oe  = (cfg_r.act_b != 2'b00) && dir_r[1];
  assign o_chan_a_wave_out = wave_a_r;
  assign o_chan_a_wave_oe  = (cfg_r.act_a != 2'b00) && dir_r[0];
endmodule : tmr8_timer

//--- verif/tmr8_checker.sv
`timescale 1ns/100ps
module tmr8_checker
  import tmr8_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        o_chan_a_wave_oe,
  input wire logic        o_chan_b_wave_out,
  input wire logic        o_chan_b_wave_oe
);
  logic       wr_r;
  logic [7:0] ad_r;
  logic [7:0] ca_r;
  logic [7:0] dir_r;

  // data phase of a write is seen one cycle after its address phase
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_r <= 1'b0;
      ad_r <= 8'h00;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      ad_r <= haddr[7:0];
    end
  end

  // shadow of control A and pin direction, built only from bus traffic
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ca_r  <= 8'h00;
      dir_r <= 8'h00;
    end else if (wr_r && ad_r == TMR8_OFF_CTRL_A) begin
      ca_r <= hwdata[7:0];
    end else if (wr_r && ad_r == TMR8_OFF_PINCFG) begin
      dir_r <= hwdata[7:0];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_read(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence

  // stopped counter keeps real matches out of the force checks
  sequence s_force_b;
    wr_r && ad_r == TMR8_OFF_CTRL_B && hwdata[6] && hwdata[3:0] == 4'h0 && !ca_r[0];
  endsequence

  a_ctrl_a_resv: assert property (s_read(TMR8_OFF_CTRL_A) |=> hrdata[3:2] == 2'b00)
    else $error("control A reserved bits read nonzero");
  a_ctrl_b_resv: assert property (s_read(TMR8_OFF_CTRL_B) |=> hrdata[7:4] == 4'h0)
    else $error("control B force or reserved bits read nonzero");
  a_b_pin_drive: assert property (o_chan_b_wave_oe == (ca_r[5:4] != 2'b00 && dir_r[1]))
    else $error("channel B drive enable wrong");
  a_a_pin_drive: assert property (o_chan_a_wave_oe == (ca_r[7:6] != 2'b00 && dir_r[0]))
    else $error("channel A drive enable wrong");
  a_force_set_b: assert property (s_force_b ##0 ca_r[5:4] == 2'b11 |-> ##[1:2] o_chan_b_wave_out)
    else $error("forced set on channel B missing");
  a_force_clr_b: assert property (s_force_b ##0 ca_r[5:4] == 2'b10 |-> ##[1:2] !o_chan_b_wave_out)
    else $error("forced clear on channel B missing");
  a_force_tog_b: assert property (s_force_b ##0 ca_r[5:4] == 2'b01 ##0 o_chan_b_wave_out
    |-> ##[1:2] !o_chan_b_wave_out)
    else $error("forced toggle on channel B missing");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule : tmr8_checker

bind tmr8_timer tmr8_checker u_chk (
  .i_clk, .i_reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .o_chan_a_wave_oe, .o_chan_b_wave_out, .o_chan_b_wave_oe
);

//--- verif/timer8_compare_waveform_control_tb.sv
`timescale 1ns/100ps
module timer8_compare_waveform_control_tb
  import tmr8_pkg::*;
;
  logic        i_clk, i_reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        i_ext_count_input, o_chan_a_wave_out, o_chan_a_wave_oe;
  logic        o_chan_b_wave_out, o_chan_b_wave_oe;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          mismatches, num_checks;

  assign hready = hreadyout;

  tmr8_timer dut (
    .i_clk, .i_reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .i_ext_count_input, .o_chan_a_wave_out,
    .o_chan_a_wave_oe, .o_chan_b_wave_out, .o_chan_b_wave_oe
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic phase;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      mismatches++;
      complete_run;
    end
  endtask : phase

  // bounded wait at falling edges for a level on channel B
  task automatic wait_b(input logic v);
    int n;
    n = 0;
    while (o_chan_b_wave_out !== v && n < 600) begin
      @(negedge i_clk);
      n++;
    end
    if (o_chan_b_wave_out !== v) begin
      mismatches++;
      complete_run;
    end
  endtask : wait_b

  // outputs are sampled at negedges, so every transfer realigns to a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    phase;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    phase;
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(q, {24'h0, e});
  endtask : rdc

  task automatic t_regs;
    rdc(TMR8_OFF_CTRL_B, 8'h00);
    wr(TMR8_OFF_CTRL_A, 8'hFF);
    rdc(TMR8_OFF_CTRL_A, 8'hF3);
    wr(TMR8_OFF_CTRL_B, 8'h38);
    rdc(TMR8_OFF_CTRL_B, 8'h08);
    wr(TMR8_OFF_CMP_A, 8'hA5);
    rdc(TMR8_OFF_CMP_A, 8'hA5);
    wr(8'h1C, 8'h5A);
    rdc(8'h1C, 8'h00);
    wr(TMR8_OFF_CTRL_A, 8'h00);
    wr(TMR8_OFF_CTRL_B, 8'h00);
  endtask : t_regs

  task automatic t_force;
    logic [7:0] ab [4] = '{8'h30, 8'h20, 8'h10, 8'h10};
    wr(TMR8_OFF_PINCFG, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(TMR8_OFF_CTRL_A, ab[i]);
      wr(TMR8_OFF_CTRL_B, 8'h40);
      repeat (2) @(negedge i_clk);
      check(o_chan_b_wave_out, {31'h0, !i[0]});
      check(o_chan_b_wave_oe, 1'h1);
    end
    rdc(TMR8_OFF_CTRL_B, 8'h00);
    rdc(TMR8_OFF_FLAGS, 8'h00);
    wr(TMR8_OFF_CTRL_A, 8'hC0);
    wr(TMR8_OFF_CTRL_B, 8'h80);
    repeat (2) @(negedge i_clk);
    check(o_chan_a_wave_out, 1'h1);
    check(o_chan_b_wave_oe, 1'h0);
  endtask : t_force

  task automatic t_match;
    int n;
    wr(TMR8_OFF_CTRL_A, 8'h30);
    wr(TMR8_OFF_CMP_B, 8'h10);
    wr(TMR8_OFF_FLAGS, 8'h07);
    wr(TMR8_OFF_CTRL_B, 8'h01);
    n = 0;
    while (o_chan_b_wave_out !== 1'b1 && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    check(o_chan_b_wave_out, 1'h1);
    if (n >= 300) complete_run;
    wr(TMR8_OFF_CTRL_B, 8'h00);
    rdc(TMR8_OFF_FLAGS, 8'h04);
    wr(TMR8_OFF_FLAGS, 8'h04);
    rdc(TMR8_OFF_FLAGS, 8'h00);
    wr(TMR8_OFF_COUNT, 8'hFE);
    wr(TMR8_OFF_CTRL_B, 8'h01);
    wr(TMR8_OFF_CTRL_B, 8'h00);
    xfer(1'b0, TMR8_OFF_FLAGS, 8'h00);
    check(q[0], 1'h1);
    wr(TMR8_OFF_FLAGS, 8'h07);
    wr(TMR8_OFF_COUNT, 8'h10);
    wr(TMR8_OFF_CTRL_B, 8'h01);
    wr(TMR8_OFF_CTRL_B, 8'h00);
    rdc(TMR8_OFF_FLAGS, 8'h00);
  endtask : t_match

  // rising select first, then falling; pin idles low so each pass sees three edges
  task automatic t_ext;
    for (int k = 0; k < 2; k++) begin
      wr(TMR8_OFF_COUNT, 8'h00);
      wr(TMR8_OFF_CTRL_B, 8'h07 - k[7:0]);
      repeat (3) begin
        i_ext_count_input <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_ext_count_input <= 1'b0;
        repeat (6) @(posedge i_clk);
      end
      wr(TMR8_OFF_CTRL_B, 8'h00);
      rdc(TMR8_OFF_COUNT, 8'h03);
    end
  endtask : t_ext

  // prescaler phase is free running, so one tick of slack either way
  task automatic t_pre;
    wr(TMR8_OFF_COUNT, 8'h00);
    rdc(TMR8_OFF_COUNT, 8'h00);
    wr(TMR8_OFF_CTRL_B, 8'h02);
    repeat (80) @(posedge i_clk);
    wr(TMR8_OFF_CTRL_B, 8'h00);
    xfer(1'b0, TMR8_OFF_COUNT, 8'h00);
    check(q >= 32'h9 && q <= 32'hB, 1'h1);
  endtask : t_pre

  // one whole high phase of channel B, phase correct then fast; then compare equal to TOP
  task automatic t_pwm;
    logic [7:0]  md [2] = '{8'h21, 8'h23};
    logic [31:0] hi [2] = '{32'h80, 32'h41};
    int          n;
    wr(TMR8_OFF_CMP_B, 8'h40);
    for (int j = 0; j < 2; j++) begin
      wr(TMR8_OFF_CTRL_A, md[j]);
      wr(TMR8_OFF_CTRL_B, 8'h01);
      wait_b(1'b0);
      wait_b(1'b1);
      n = 0;
      while (o_chan_b_wave_out === 1'b1 && n < 300) begin
        @(negedge i_clk);
        n++;
      end
      check(n, hi[j]);
    end
    // the new compare value only takes effect at TOP, so let one period pass first
    wr(TMR8_OFF_CMP_B, 8'hFF);
    repeat (300) @(negedge i_clk);
    n = 0;
    repeat (300) begin
      @(negedge i_clk);
      if (o_chan_b_wave_out !== 1'b1) n++;
    end
    check(n, 32'h0);
    wr(TMR8_OFF_CTRL_B, 8'h00);
    wr(TMR8_OFF_CTRL_A, 8'h00);
  endtask : t_pwm

  initial begin
    i_reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    i_ext_count_input = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs;
    t_force;
    t_match;
    t_ext;
    t_pre;
    t_pwm;
    complete_run;
  end
endmodule : timer8_compare_waveform_control_tb
